// *** common/dmem_pkg.sv ***
// Package for the internal data memory and special-register decode block.
// Assumes a single system clock; shared by the design and its bench.
package dmem_pkg;
  // ==========================================================================
  // Memory map
  localparam int RAM_BYTES = 256;
  localparam logic [7:0] LOWER_TOP = 8'h7f;
  localparam logic [7:0] BANK_TOP = 8'h1f;
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam logic [7:0] BIT_BYTE_TOP = 8'h2f;
  localparam logic [7:0] BIT_AREA_TOP = 8'h7f;
  // ==========================================================================
  // Special-register offsets held in this block
  localparam logic [7:0] STACK_POINTER_ADDR = 8'h81;
  localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hd0;
  localparam logic [7:0] PAGE_SELECT_TOP_ADDR = 8'h84;
  localparam logic [7:0] PAGE_STACK_MIDDLE_ADDR = 8'h85;
  localparam logic [7:0] PAGE_STACK_BOTTOM_ADDR = 8'h86;
  localparam logic [7:0] PAGE_CONTROL_REG_ADDR = 8'h96;
  localparam logic [7:0] STACK_RECORD_STATUS_ADDR = 8'h97;
  // Port registers that appear on every page
  localparam logic [7:0] PORT0_ADDR = 8'h80;
  localparam logic [7:0] PORT1_ADDR = 8'h90;
  localparam logic [7:0] PORT2_ADDR = 8'ha0;
  localparam logic [7:0] PORT3_ADDR = 8'hb0;
  // ==========================================================================
  // Field positions and reset values
  localparam int BANK_SELECT_LOW_BIT = 3;
  localparam int BANK_SELECT_HIGH_BIT = 4;
  localparam int AUTO_PAGE_ENABLE_BIT = 0;
  localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] PAGE_CONTROL_RESET = 8'h01;
  localparam logic [7:0] PAGE_EMPTY = 8'h00;
  localparam int RECORD_BITS = 32;
  // Pages implemented on this device
  localparam logic [7:0] PAGE_0 = 8'h00;
  localparam logic [7:0] PAGE_1 = 8'h01;
  localparam logic [7:0] PAGE_2 = 8'h02;
  localparam logic [7:0] PAGE_3 = 8'h03;
  localparam logic [7:0] PAGE_F = 8'h0f;
  // ==========================================================================
  // Stack-record operations from the core
  typedef enum logic [2:0] {
    REC_NONE,
    REC_PUSH1,
    REC_PUSH2,
    REC_POP1,
    REC_POP2
  } rec_op_t;
endpackage

// *** core/data_memory_sfr_paging.sv ***
// Internal data RAM, working-register banks, bit area, stack pointer,
// stack record and special-register page stack with access steering.
// Assumes the core drives one access per cycle on clk; reads return next cycle.
`timescale 1ns/1ps

module data_memory_sfr_paging
  import dmem_pkg::*;
#(
  parameter int RECORD_WIDTH = RECORD_BITS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic accEn,
  input wire logic accWrite,
  input wire logic accIndirect,
  input wire logic accBit,
  input wire logic [7:0] accAddr,
  input wire logic [7:0] accWdata,
  input wire logic accWbit,
  input wire logic ptrSel,
  input wire logic useIndexPtr,
  input wire logic spPush,
  input wire logic spPop,
  input wire logic [2:0] recOp,
  input wire logic intEntry,
  input wire logic [7:0] intPage,
  input wire logic intReturn,
  output logic [7:0] rdData,
  output logic rdBit,
  output logic rdValid,
  output logic sfrSel,
  output logic [7:0] sfrAddr,
  output logic [7:0] page_select_top,
  output logic sfrAllPages,
  output logic sfrBitOk,
  output logic [7:0] stackPointer,
  output logic [1:0] activeBank,
  output logic recOverflow,
  output logic recUnderflow,
  output logic autoPageOn
);

  // ==========================================================================
  // Storage
  // The array has no reset; software writes a byte before relying on it
  logic [7:0] ram [RAM_BYTES];
  logic [7:0] stack_pointer_reg;
  logic [7:0] program_status_word_reg;
  logic [7:0] page_select_top_reg;
  logic [7:0] page_stack_middle_reg;
  logic [7:0] page_stack_bottom_reg;
  logic [7:0] page_control_reg;
  logic [RECORD_WIDTH-1:0] record_reg;
  logic [5:0] recDepth_reg;
  logic ovf_reg;
  logic unf_reg;

  // Byte address of a working register in the current bank
  function automatic logic [7:0] bankAddr(input logic [1:0] bank, input logic [2:0] idx);
    bankAddr = {3'h0, bank, idx};
  endfunction

  // Bit address to byte address in the bit area
  function automatic logic [7:0] bitByte(input logic [7:0] bitAddr);
    bitByte = BIT_BYTE_BASE + {4'h0, bitAddr[6:3]};
  endfunction

  // ==========================================================================
  // Address steering
  logic [1:0] bank;
  logic [7:0] ptrVal;
  logic [7:0] effAddr;
  logic toSfr;
  logic localSfr;
  logic autoEn;
  logic allPage;

  assign bank = {program_status_word_reg[BANK_SELECT_HIGH_BIT],
                 program_status_word_reg[BANK_SELECT_LOW_BIT]};
  assign ptrVal = ram[bankAddr(bank, {2'h0, ptrSel})];
  assign autoEn = page_control_reg[AUTO_PAGE_ENABLE_BIT];

  // Bit operand type alone picks the bit path; a bit address >0x7f is in special space
  always_comb begin
    effAddr = useIndexPtr ? ptrVal : accAddr;
    toSfr = 1'b0;
    if (accBit) begin
      if (accAddr > BIT_AREA_TOP) begin
        effAddr = {accAddr[7:3], 3'h0};
        toSfr = 1'b1;
      end else begin
        effAddr = bitByte(accAddr);
      end
    end else if (!accIndirect && effAddr > LOWER_TOP) begin
      toSfr = 1'b1;
    end
  end

  // Registers held here answer on every page; ports 0-3 also span pages
  // Local registers never pulse sfrSel, so no peripheral sees their traffic
  assign localSfr = (effAddr == STACK_POINTER_ADDR) || (effAddr == PROGRAM_STATUS_WORD_ADDR)
                 || (effAddr == PAGE_SELECT_TOP_ADDR) || (effAddr == PAGE_STACK_MIDDLE_ADDR)
                 || (effAddr == PAGE_STACK_BOTTOM_ADDR) || (effAddr == PAGE_CONTROL_REG_ADDR)
                 || (effAddr == STACK_RECORD_STATUS_ADDR);
  assign allPage = (effAddr == PORT0_ADDR) || (effAddr == PORT1_ADDR)
                || (effAddr == PORT2_ADDR) || (effAddr == PORT3_ADDR);

  logic ramWr;
  logic sfrWr;
  logic [7:0] ramOld;
  logic [7:0] ramNew;
  assign ramWr = accEn && accWrite && !toSfr;
  assign sfrWr = accEn && accWrite && toSfr && localSfr;
  assign ramOld = ram[effAddr];

  // Bit writes do a read-modify-write of the owning byte
  always_comb begin
    ramNew = accWdata;
    if (accBit) begin
      ramNew = ramOld;
      ramNew[accAddr[2:0]] = accWbit;
    end
  end

  // ==========================================================================
  // RAM array; push writes at pointer plus one
  // A push and a byte write in one cycle: the push wins, the write is lost
  always_ff @(posedge clk) begin
    if (spPush) begin
      ram[stack_pointer_reg + 8'h01] <= accWdata;
    end else if (ramWr) begin
      ram[effAddr] <= ramNew;
    end
  end

  // ==========================================================================
  // Stack pointer; direct write loses to a push in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_pointer_reg <= STACK_POINTER_RESET;
    end else if (spPush) begin
      stack_pointer_reg <= stack_pointer_reg + 8'h01;
    end else if (spPop) begin
      stack_pointer_reg <= stack_pointer_reg - 8'h01;
    end else if (sfrWr && effAddr == STACK_POINTER_ADDR) begin
      stack_pointer_reg <= sfrNewByte(stack_pointer_reg);
    end
  end

  // Byte or bit update of a local special register
  function automatic logic [7:0] sfrNewByte(input logic [7:0] old);
    sfrNewByte = accWdata;
    if (accBit) begin
      sfrNewByte = old;
      sfrNewByte[accAddr[2:0]] = accWbit;
    end
  endfunction

  // Status word holds the bank select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_status_word_reg <= 8'h00;
    end else if (sfrWr && effAddr == PROGRAM_STATUS_WORD_ADDR) begin
      program_status_word_reg <= sfrNewByte(program_status_word_reg);
    end
  end

  // ==========================================================================
  // Page stack; hardware push/pop beat a software write in the same cycle
  logic pushPg;
  logic popPg;
  // Entry beats return in one cycle so the new handler's page is not lost
  assign pushPg = intEntry && autoEn;
  assign popPg = intReturn && autoEn && !intEntry;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_select_top_reg <= PAGE_RESET;
      page_stack_middle_reg <= PAGE_RESET;
      page_stack_bottom_reg <= PAGE_RESET;
    end else if (pushPg) begin
      page_select_top_reg <= intPage;
      page_stack_middle_reg <= page_select_top_reg;
      page_stack_bottom_reg <= page_stack_middle_reg;
    end else if (popPg) begin
      page_select_top_reg <= page_stack_middle_reg;
      page_stack_middle_reg <= page_stack_bottom_reg;
      page_stack_bottom_reg <= PAGE_EMPTY;
    end else if (sfrWr) begin
      if (effAddr == PAGE_SELECT_TOP_ADDR) begin
        page_select_top_reg <= sfrNewByte(page_select_top_reg);
      end
      if (effAddr == PAGE_STACK_MIDDLE_ADDR) begin
        page_stack_middle_reg <= sfrNewByte(page_stack_middle_reg);
      end
      if (effAddr == PAGE_STACK_BOTTOM_ADDR) begin
        page_stack_bottom_reg <= sfrNewByte(page_stack_bottom_reg);
      end
    end
  end

  // Page control; enable comes up set
  // Only the enable bit is stored; the other bits read back as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_control_reg <= PAGE_CONTROL_RESET;
    end else if (sfrWr && effAddr == PAGE_CONTROL_REG_ADDR) begin
      page_control_reg <= sfrNewByte(page_control_reg) & PAGE_CONTROL_RESET;
    end
  end

  // ==========================================================================
  // Stack record: shift register with a depth count to spot over/underflow
  logic [5:0] recIn;
  logic [5:0] recOut;
  always_comb begin
    recIn = 6'h00;
    recOut = 6'h00;
    case (rec_op_t'(recOp))
      REC_PUSH1: recIn = 6'h01;
      REC_PUSH2: recIn = 6'h02;
      REC_POP1: recOut = 6'h01;
      REC_POP2: recOut = 6'h02;
      default: begin
        recIn = 6'h00;
        recOut = 6'h00;
      end
    endcase
  end

  // Flags are sticky until reset; debug reads them at full speed
  // Depth saturates at the width, so a runaway loop cannot wrap to a legal count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      record_reg <= '0;
      recDepth_reg <= 6'h00;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else if (recIn != 6'h00) begin
      record_reg <= (recIn == 6'h02) ? {record_reg[RECORD_WIDTH-3:0], 2'h3}
                                     : {record_reg[RECORD_WIDTH-2:0], 1'b1};
      if ({1'b0, recDepth_reg} + {1'b0, recIn} > 7'(RECORD_WIDTH)) begin
        ovf_reg <= 1'b1;
        recDepth_reg <= 6'(RECORD_WIDTH);
      end else begin
        recDepth_reg <= recDepth_reg + recIn;
      end
    end else if (recOut != 6'h00) begin
      record_reg <= (recOut == 6'h02) ? {2'h0, record_reg[RECORD_WIDTH-1:2]}
                                      : {1'b0, record_reg[RECORD_WIDTH-1:1]};
      if (recDepth_reg < recOut) begin
        unf_reg <= 1'b1;
        recDepth_reg <= 6'h00;
      end else begin
        recDepth_reg <= recDepth_reg - recOut;
      end
    end
  end

  // ==========================================================================
  // Read path and special-register hand-off, all registered
  // External special registers read as zero here; their peripheral answers
  logic [7:0] localRd;
  always_comb begin
    case (effAddr)
      STACK_POINTER_ADDR: localRd = stack_pointer_reg;
      PROGRAM_STATUS_WORD_ADDR: localRd = program_status_word_reg;
      PAGE_SELECT_TOP_ADDR: localRd = page_select_top_reg;
      PAGE_STACK_MIDDLE_ADDR: localRd = page_stack_middle_reg;
      PAGE_STACK_BOTTOM_ADDR: localRd = page_stack_bottom_reg;
      PAGE_CONTROL_REG_ADDR: localRd = page_control_reg;
      STACK_RECORD_STATUS_ADDR: localRd = {6'h00, unf_reg, ovf_reg};
      default: localRd = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 8'h00;
      rdBit <= 1'b0;
      rdValid <= 1'b0;
      sfrSel <= 1'b0;
      sfrAddr <= 8'h00;
      page_select_top <= 8'h00;
      sfrAllPages <= 1'b0;
      sfrBitOk <= 1'b0;
    end else begin
      rdValid <= accEn && !accWrite;
      rdData <= toSfr ? localRd : ramOld;
      rdBit <= toSfr ? localRd[accAddr[2:0]] : ramOld[accAddr[2:0]];
      sfrSel <= accEn && toSfr && !localSfr;
      sfrAddr <= effAddr;
      page_select_top <= page_select_top_reg;
      sfrAllPages <= allPage;
      sfrBitOk <= (effAddr[3:0] == 4'h0) || (effAddr[3:0] == 4'h8);
    end
  end

  // Status mirrors
  // One cycle behind their registers, so every output leaves a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stackPointer <= STACK_POINTER_RESET;
      activeBank <= 2'h0;
      recOverflow <= 1'b0;
      recUnderflow <= 1'b0;
      autoPageOn <= 1'b1;
    end else begin
      stackPointer <= stack_pointer_reg;
      activeBank <= bank;
      recOverflow <= ovf_reg;
      recUnderflow <= unf_reg;
      autoPageOn <= autoEn;
    end
  end

endmodule

// *** tb/core_model.sv ***
// Core-side model: one access or event per clock, applied at the falling edge.
// Assumes a single calling process; the page-select write precedes paged access.
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  output logic accEn,
  output logic accWrite,
  output logic accIndirect,
  output logic accBit,
  output logic [7:0] accAddr,
  output logic [7:0] accWdata,
  output logic accWbit,
  output logic ptrSel,
  output logic useIndexPtr,
  output logic spPush,
  output logic spPop,
  output logic [2:0] recOp,
  output logic intEntry,
  output logic [7:0] intPage,
  output logic intReturn
);
  // Quiet core at time zero
  initial begin
    {spPop, spPush, ptrSel, useIndexPtr, accBit, accIndirect, accWrite, accEn} = 8'h00;
    {accAddr, accWdata, intPage, recOp, accWbit, intEntry, intReturn} = '0;
  end
  // One cycle of activity; c packs the access controls, e the events
  task automatic cyc(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
      input logic [4:0] e = 5'h00);
    @(negedge clk);
    {spPop, spPush, ptrSel, useIndexPtr, accBit, accIndirect, accWrite, accEn} = c;
    accAddr = a;
    accWdata = d;
    accWbit = d[0];
    recOp = e[2:0];
    intEntry = e[3];
    intReturn = e[4];
    if (e[3]) intPage = d; // Page held between entries, like the flag source
  endtask
endmodule

// *** tb/data_memory_sfr_paging_assertions.sv ***
// Checker for the data memory block, bound to its top module.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
module data_memory_sfr_paging_assertions
  import dmem_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic accEn,
  input wire logic accWrite,
  input wire logic accIndirect,
  input wire logic accBit,
  input wire logic [7:0] accAddr,
  input wire logic useIndexPtr,
  input wire logic spPush,
  input wire logic spPop,
  input wire logic intEntry,
  input wire logic [7:0] intPage,
  input wire logic intReturn,
  input wire logic rdValid,
  input wire logic sfrSel,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] page_select_top,
  input wire logic sfrAllPages,
  input wire logic sfrBitOk,
  input wire logic [7:0] stackPointer,
  input wire logic autoPageOn
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Stack untouched, so the mirror only moves for the push under test
  sequence quiet_s;
    !spPush && !spPop && !accEn;
  endsequence
  sequence lone_push_s;
    quiet_s [*2] ##1 (spPush && !accEn) ##1 quiet_s;
  endsequence
  sequence lone_entry_s;
    (intEntry && autoPageOn && !accEn) ##1 ($stable(intPage) && !intEntry && !intReturn);
  endsequence
  reset_values_a: assert property (
    $rose(rst_n) |-> stackPointer == STACK_POINTER_RESET && autoPageOn)
    else $error("reset values wrong");
  push_step_a: assert property (
    lone_push_s |-> ##1 stackPointer == $past(stackPointer, 2) + 8'h01)
    else $error("push did not step pointer");
  read_answer_a: assert property (
    accEn && !accWrite |=> rdValid) else $error("read answer missing");
  write_quiet_a: assert property (
    accEn && accWrite |=> !rdValid) else $error("write gave read answer");
  indirect_ram_a: assert property (
    accEn && accIndirect |=> !sfrSel) else $error("indirect reached special space");
  direct_port_a: assert property (
    accEn && !accIndirect && !accBit && !useIndexPtr && accAddr == PORT1_ADDR
    |=> sfrSel && sfrAddr == PORT1_ADDR && sfrAllPages) else $error("port decode wrong");
  bit_ok_a: assert property (
    sfrSel |-> sfrBitOk == (sfrAddr[2:0] == 3'h0)) else $error("bit access flag wrong");
  entry_page_a: assert property (
    lone_entry_s |-> ##[0:1] page_select_top == intPage) else $error("entry page not loaded");
endmodule

bind data_memory_sfr_paging data_memory_sfr_paging_assertions u_chk (
  .clk, .rst_n, .accEn, .accWrite, .accIndirect, .accBit, .accAddr, .useIndexPtr,
  .spPush, .spPop, .intEntry, .intPage, .intReturn, .rdValid, .sfrSel, .sfrAddr,
  .page_select_top, .sfrAllPages, .sfrBitOk, .stackPointer, .autoPageOn
);

// *** tb/data_memory_sfr_paging_tb.sv ***
// Self-checking bench for the data memory and page-stack block.
// Assumes the core model drives inputs; read answers are scored in order.
`timescale 1ns/1ps
module data_memory_sfr_paging_tb;
  import dmem_pkg::*;
  localparam logic [7:0] R = 8'h01, W = 8'h03, RI = 8'h05, WI = 8'h07, WB = 8'h0b;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic accEn, accWrite, accIndirect, accBit, accWbit, ptrSel, useIndexPtr, spPush, spPop;
  logic intEntry, intReturn, rdBit, rdValid, sfrSel, sfrAllPages, sfrBitOk;
  logic recOverflow, recUnderflow, autoPageOn;
  logic [7:0] accAddr, accWdata, intPage, rdData, sfrAddr, page_select_top, stackPointer, dv;
  logic [8:0] dq;
  logic [2:0] recOp;
  logic [1:0] activeBank;
  logic [8:0] expq[$];
  int n_fail = 0;
  int compares = 0;
  // ==========================================================================
  // Design, core model, clock
  data_memory_sfr_paging u_data_memory_sfr_paging (.clk, .rst_n, .accEn, .accWrite,
    .accIndirect, .accBit, .accAddr, .accWdata, .accWbit, .ptrSel, .useIndexPtr, .spPush,
    .spPop, .recOp, .intEntry, .intPage, .intReturn, .rdData, .rdBit, .rdValid, .sfrSel,
    .sfrAddr, .page_select_top, .sfrAllPages, .sfrBitOk, .stackPointer, .activeBank, .recOverflow,
    .recUnderflow, .autoPageOn);
  core_model u_core_model (.clk, .accEn, .accWrite, .accIndirect, .accBit, .accAddr,
    .accWdata, .accWbit, .ptrSel, .useIndexPtr, .spPush, .spPop, .recOp, .intEntry,
    .intPage, .intReturn);
  always #2.5 clk = ~clk;
  // ==========================================================================
  // Tasks
  task automatic op(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
      input logic [4:0] e = 5'h00);
    u_core_model.cyc(c, a, d, e);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] x);
    op(c, a, 8'($urandom));
    expq.push_back({x[a[2:0]], x});
  endtask
  // Immediate check of a settled output, taken at the falling edge
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    compares++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // Released bus shows the inverse of its last value
  task automatic idle(input int n);
    repeat (n) op(8'h00, ~accAddr, ~accWdata);
  endtask
  task automatic pg(input logic [7:0] t, input logic [7:0] m, input logic [7:0] b);
    rd(R, PAGE_SELECT_TOP_ADDR, t);
    rd(R, PAGE_STACK_MIDDLE_ADDR, m);
    rd(R, PAGE_STACK_BOTTOM_ADDR, b);
  endtask
  task automatic note(input string s);
    idle(2);
    $display("test %0s done", s);
  endtask
  task automatic reset_dut();
    idle(2);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Scoreboard: oldest note against each answer
  always @(negedge clk) begin
    if (rdValid !== 1'b0) begin
      compares++;
      dq = expq.pop_front();
      if ({rdBit, rdData} !== dq) begin
        n_fail++;
        $display("MISMATCH t=%0t got %h exp %h", $time, {rdBit, rdData}, dq);
      end
    end
  end
  // Watchdog, far beyond the fewer than 150 cycles the tests take
  initial begin
    #20000;
    n_fail++;
    end_sim();
  end
  // ==========================================================================
  // Tests
  initial begin
    void'($urandom(32'h448a1ee9));
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    rd(R, STACK_POINTER_ADDR, STACK_POINTER_RESET);
    rd(R, PAGE_CONTROL_REG_ADDR, PAGE_CONTROL_RESET);
    pg(PAGE_RESET, PAGE_RESET, PAGE_EMPTY);
    note("reset");
    dv = 8'($urandom);
    op(W, 8'h30, dv);
    op(WI, 8'h90, dv ^ 8'h5a);
    op(W, PORT1_ADDR, ~dv);
    op(W, 8'h99, dv);
    op(WI, 8'hff, ~dv);
    chk({5'h00, sfrSel, sfrBitOk, sfrAllPages}, 8'h04);
    chk(sfrAddr, 8'h99);
    rd(RI, 8'h30, dv);
    rd(RI, 8'h90, dv ^ 8'h5a);
    rd(R, PORT1_ADDR, 8'h00);
    rd(RI, 8'hff, ~dv);
    note("steering");
    for (int b = 0; b < 4; b++) begin
      dv = 8'($urandom);
      op(W, PROGRAM_STATUS_WORD_ADDR, 8'(b << 3));
      op(W, 8'(b * 8), 8'h40 + 8'(b));
      op(W, 8'(b * 8 + 1), 8'h50 + 8'(b));
      op(W, 8'h40 + 8'(b), dv);
      op(W, 8'h50 + 8'(b), ~dv);
      rd(8'h15, 8'h00, dv);
      rd(8'h35, 8'h00, ~dv);
      chk({6'h00, activeBank}, 8'(b));
    end
    op(W, PROGRAM_STATUS_WORD_ADDR, 8'h00);
    note("banks");
    dv = 8'($urandom);
    op(W, 8'h13, dv);
    op(W, 8'h22, 8'h00);
    op(WB, 8'h13, 8'h01);
    rd(R, 8'h22, 8'h08);
    rd(8'h09, 8'h13, 8'h08);
    rd(R, 8'h13, dv);
    note("bits");
    dv = 8'($urandom);
    op(8'h40, 8'h00, dv);
    idle(1);
    rd(R, 8'h08, dv);
    rd(R, STACK_POINTER_ADDR, 8'h08);
    op(8'h80, 8'h00, 8'h00);
    rd(R, STACK_POINTER_ADDR, 8'h07);
    note("stack");
    op(W, PAGE_SELECT_TOP_ADDR, PAGE_F);
    idle(1);
    op(8'h00, 8'h00, PAGE_2, 5'h08);
    idle(2);
    op(8'h00, 8'h00, PAGE_0, 5'h08);
    idle(2);
    pg(PAGE_0, PAGE_2, PAGE_F);
    op(8'h00, 8'h00, 8'h00, 5'h10);
    pg(PAGE_2, PAGE_F, PAGE_EMPTY);
    op(W, PAGE_STACK_BOTTOM_ADDR, PAGE_3);
    pg(PAGE_2, PAGE_F, PAGE_3);
    op(8'h00, 8'h00, 8'h00, 5'h10);
    pg(PAGE_F, PAGE_3, PAGE_EMPTY);
    op(W, PAGE_CONTROL_REG_ADDR, 8'h00);
    idle(2);
    chk({7'h00, autoPageOn}, 8'h00);
    op(8'h00, 8'h00, PAGE_1, 5'h08);
    op(8'h00, 8'h00, 8'h00, 5'h10);
    pg(PAGE_F, PAGE_3, PAGE_EMPTY);
    op(W, PAGE_CONTROL_REG_ADDR, 8'h01);
    note("paging");
    reset_dut();
    for (int i = 0; i < 16; i++) op(8'h00, 8'h00, 8'h00, 5'h02);
    idle(1);
    rd(R, STACK_RECORD_STATUS_ADDR, 8'h00);
    chk({6'h00, recUnderflow, recOverflow}, 8'h00);
    op(8'h00, 8'h00, 8'h00, 5'h01);
    idle(1);
    rd(R, STACK_RECORD_STATUS_ADDR, 8'h01);
    chk({6'h00, recUnderflow, recOverflow}, 8'h01);
    reset_dut();
    op(8'h00, 8'h00, 8'h00, 5'h03);
    idle(1);
    rd(R, STACK_RECORD_STATUS_ADDR, 8'h02);
    chk({6'h00, recUnderflow, recOverflow}, 8'h02);
    note("record");
    compares++;
    if (expq.size() != 0) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, expq.size(), 0);
    end
    end_sim();
  end
endmodule
